// file: core/flash_iap_access.sv
// module: flash access control, byte programming and memory map decode
//
// Contract
// - last two flash bytes form config word
// - lowest flash range holds reset vectors
// - free data sector always readable and writable
// - lock gates lowest sector code and data
// - main sector data access needs wide-write flag
// - command 65h sets flag, else clears
// - command port reads flag in bit 0
// - high config never data reachable
// - low config copied to register at power-on
// - lock bit is high config bit 5
// - data store programs one byte, 500 us
// - cpu waits, interrupts held while programming
// - byte writes, no page erase
// - flash reads add no wait cycles
// - only 254 bytes writable after reset
// - indirect reaches 256 bytes, direct 128
// - four register banks below 20h
// - 20h to 2Fh bit addressable
// - external ram at top of data space
// - sfrs in upper half, 14 bit-addressable
`timescale 1ns/100ps
module flash_iap_access
  import flash_iap_pkg::*;
#(
  parameter int unsigned PROG_COUNT = PROG_CYCLES  // programming length in clocks
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rst,
  // power-on config load
  input  wire logic                       por_load,
  input  wire logic [7:0]                 cfg_high_in,
  input  wire logic [7:0]                 cfg_low_in,
  // special function register port
  input  wire flash_iap_pkg::sfr_req_t    sfr_req,
  output logic [7:0]                      sfr_rdata,
  // code read port
  input  wire logic [15:0]                code_addr,
  input  wire logic                       code_rd,
  input  wire logic [7:0]                 flash_code_in,
  output logic [7:0]                      code_rdata,
  output logic                            code_ok,
  // external data port
  input  wire flash_iap_pkg::xdata_req_t  x_req,
  input  wire logic [7:0]                 flash_x_in,
  output logic [7:0]                      x_rdata,
  output logic                            x_ok,
  // flash programming port
  output logic [13:0]                     flash_wr_addr,
  output logic [7:0]                      flash_wr_data,
  output logic                            flash_prog,
  // cpu control
  output logic                            cpu_wait,
  output logic                            irq_hold,
  output logic                            soft_reset_trigger,
  output logic                            code_read_lock,
  output logic                            wide_write_flag,
  output logic [7:0]                      config_word_low,
  // internal data space decode
  input  wire flash_iap_pkg::dspace_req_t d_req,
  output flash_iap_pkg::dspace_ans_t      d_ans
);

  //////////////////////////////////////////////////////////////////////////////
  // access functions

  // code read permission per sector
  function automatic logic code_allowed(input logic [15:0] a, input logic lk);
    logic ok;
    ok = 1'b0;
    if (a > CFG_HIGH_ADDR) begin
      ok = 1'b0;                          // beyond the flash
    end else if (a <= LOCK_END) begin
      ok = !lk;
    end else begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  // external data permission per sector, same for read and write
  function automatic logic data_allowed(input logic [15:0] a, input logic lk,
                                        input logic wf);
    logic ok;
    ok = 1'b0;
    if (a <= LOCK_END) begin
      ok = !lk && wf;
    end else if (a <= MAIN_END) begin
      ok = wf;
    end else if (a <= FREE_END) begin
      ok = 1'b1;
    end else if (a == CFG_LOW_ADDR) begin
      ok = wf;
    end else begin
      ok = 1'b0;                          // high config and above
    end
    return ok;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state

  state_t s;       // registered state
  state_t n;       // next state

  logic   x_flash; // external access lands in flash
  logic   x_ram;   // external access lands in external ram

  //////////////////////////////////////////////////////////////////////////////
  // next state logic
  always_comb begin
    n           = s;
    n.soft_rst  = 1'b0;
    x_flash     = (x_req.addr <= CFG_HIGH_ADDR);
    x_ram       = (x_req.addr >= XRAM_BASE);

    // power-on load of the config word; other resets leave it cleared
    if (por_load) begin
      n.lock    = cfg_high_in[LOCK_BIT_POS];
      n.cfg_low = cfg_low_in;
    end

    // special function register writes
    if (sfr_req.wr) begin
      if (sfr_req.addr == CMD_PORT_ADDR) begin
        n.wide     = (sfr_req.wdata == WIDE_KEY);
        n.soft_rst = (sfr_req.wdata == SOFT_RST_KEY);
      end else if (sfr_req.addr == CFG_SFR_ADDR) begin
        n.cfg_low = sfr_req.wdata;
      end
    end

    // special function register reads, unowned addresses read zero
    if (sfr_req.rd) begin
      if (sfr_req.addr == CMD_PORT_ADDR) begin
        n.sfr_rdata               = 8'h00;
        n.sfr_rdata[WIDE_BIT_POS] = s.wide;
      end else if (sfr_req.addr == CFG_SFR_ADDR) begin
        n.sfr_rdata = s.cfg_low;
      end else begin
        n.sfr_rdata = 8'h00;
      end
    end

    // code reads answer next cycle with no stall; vectors sit in sector 0
    n.code_ok = 1'b0;
    if (code_rd) begin
      n.code_ok    = code_allowed(code_addr, s.lock);
      n.code_rdata = n.code_ok ? flash_code_in : 8'h00;
    end

    // external data reads
    n.x_ok = 1'b0;
    if (x_req.rd) begin
      if (x_flash) begin
        n.x_ok    = data_allowed(x_req.addr, s.lock, s.wide);
        n.x_rdata = n.x_ok ? flash_x_in : 8'h00;
      end else if (x_ram) begin
        n.x_ok    = 1'b1;
        n.x_rdata = s.xram[x_req.addr[8:0]];
      end else begin
        n.x_rdata = 8'h00;                                    // unmapped
      end
    end

    // external ram writes take effect at once
    if (x_req.wr && x_ram) begin
      n.xram[x_req.addr[8:0]] = x_req.wdata;
    end

    // byte programming sequencer
    case (s.ps)
      PS_IDLE: begin
        // only permitted flash stores start a program; after reset this is
        // the free data sector alone
        if (x_req.wr && x_flash &&
            data_allowed(x_req.addr, s.lock, s.wide)) begin
          n.ps       = PS_PROG;
          n.f_addr   = x_req.addr[13:0];
          n.f_data   = x_req.wdata;
          n.prog     = 1'b1;
          n.cpu_wait = 1'b1;
          n.cnt      = 16'(PROG_COUNT - 1);
        end
      end
      PS_PROG: begin
        // cpu and interrupts held until the byte is in
        if (s.cnt == 16'h0000) begin
          n.ps       = PS_IDLE;
          n.prog     = 1'b0;
          n.cpu_wait = 1'b0;
        end else begin
          n.cnt = s.cnt - 16'h0001;
        end
      end
      default: begin
        n.ps = PS_IDLE;
      end
    endcase

    // internal data space decode
    n.dans.iram_sel = d_req.indirect || (d_req.addr <= DIRECT_TOP);
    n.dans.sfr_sel  = !d_req.indirect && (d_req.addr > DIRECT_TOP);
    n.dans.reg_addr = {3'b000, d_req.bank, d_req.reg_num};
    n.dans.bit_index = d_req.bit_addr[2:0];
    if (d_req.bit_addr <= DIRECT_TOP) begin
      n.dans.bit_byte = BIT_RAM_BASE + {4'h0, d_req.bit_addr[6:3]};
      n.dans.bit_ok   = 1'b1;
    end else begin
      n.dans.bit_byte = {d_req.bit_addr[7:3], 3'b000};
      n.dans.bit_ok   = SFR_BIT_MASK[d_req.bit_addr[6:3]];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register; reset clears external ram along with the rest of the state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s            <= '0;
      s.ps         <= PS_IDLE;
      s.wide       <= WIDE_RST;
      s.lock       <= LOCK_RST;
      s.cfg_low    <= CFG_LOW_RST;
    end else begin
      s <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  assign sfr_rdata          = s.sfr_rdata;
  assign code_rdata         = s.code_rdata;
  assign code_ok            = s.code_ok;
  assign x_rdata            = s.x_rdata;
  assign x_ok               = s.x_ok;
  assign flash_wr_addr      = s.f_addr;
  assign flash_wr_data      = s.f_data;
  assign flash_prog         = s.prog;
  assign cpu_wait           = s.cpu_wait;
  assign irq_hold           = s.cpu_wait;
  assign soft_reset_trigger = s.soft_rst;
  assign code_read_lock     = s.lock;
  assign wide_write_flag    = s.wide;
  assign config_word_low    = s.cfg_low;
  assign d_ans              = s.dans;

endmodule

// file: core/flash_iap_pkg.sv
// package: constants, types and port structs for the flash access block
package flash_iap_pkg;

  // special function register addresses
  localparam logic [7:0]  CMD_PORT_ADDR = 8'h97;   // command port
  localparam logic [7:0]  CFG_SFR_ADDR  = 8'hF7;   // low config byte copy
  localparam logic [7:0]  WIDE_KEY      = 8'h65;   // sets the wide-write flag
  localparam logic [7:0]  SOFT_RST_KEY  = 8'h56;   // soft reset request
  localparam int          WIDE_BIT_POS  = 0;       // flag position on read
  localparam int          LOCK_BIT_POS  = 5;       // lock bit in high config byte

  // program flash sectors
  localparam logic [15:0] VECTOR_END    = 16'h005F; // reset and interrupt vectors
  localparam logic [15:0] LOCK_END      = 16'h01FF; // lowest, lockable sector
  localparam logic [15:0] MAIN_END      = 16'h3EFF; // main sector
  localparam logic [15:0] FREE_END      = 16'h3FFD; // free data sector
  localparam logic [15:0] CFG_LOW_ADDR  = 16'h3FFE; // low config byte
  localparam logic [15:0] CFG_HIGH_ADDR = 16'h3FFF; // high config byte
  localparam logic [15:0] EMU_START     = 16'h1D00; // emulation reserved range
  localparam logic [15:0] EMU_END       = 16'h1FFF;
  localparam logic [15:0] XRAM_BASE     = 16'hFE00; // external ram, top of space

  // internal data space
  localparam logic [7:0]  DIRECT_TOP    = 8'h7F;    // direct ram reach
  localparam logic [7:0]  BIT_RAM_BASE  = 8'h20;    // bit addressable ram
  localparam logic [15:0] SFR_BIT_MASK  = 16'hBFBF; // 14 bit-addressable sfr rows

  // reset values
  localparam logic [7:0]  CFG_LOW_RST   = 8'h00;
  localparam logic        WIDE_RST      = 1'b0;
  localparam logic        LOCK_RST      = 1'b0;

  // byte programming time
  localparam int          PROG_TIME_US  = 500;
  localparam int          CLK_MHZ       = 50;
  localparam int          PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;

  typedef enum logic [0:0] {PS_IDLE, PS_PROG} prog_state_t;

  // special function register access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sfr_req_t;

  // external data access
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } xdata_req_t;

  // internal data space decode request
  typedef struct packed {
    logic [7:0] addr;
    logic       indirect;
    logic [1:0] bank;
    logic [2:0] reg_num;
    logic [7:0] bit_addr;
  } dspace_req_t;

  // internal data space decode answer
  typedef struct packed {
    logic       iram_sel;
    logic       sfr_sel;
    logic [7:0] reg_addr;
    logic [7:0] bit_byte;
    logic [2:0] bit_index;
    logic       bit_ok;
  } dspace_ans_t;

  // whole module state
  typedef struct packed {
    prog_state_t      ps;
    logic [15:0]      cnt;
    logic             wide;
    logic             lock;
    logic [7:0]       cfg_low;
    logic [7:0]       sfr_rdata;
    logic [7:0]       code_rdata;
    logic             code_ok;
    logic [7:0]       x_rdata;
    logic             x_ok;
    logic [13:0]      f_addr;
    logic [7:0]       f_data;
    logic             prog;
    logic             cpu_wait;
    logic             soft_rst;
    dspace_ans_t      dans;
    logic [511:0][7:0] xram;
  } state_t;

endpackage

// file: dv/flash_array_model.sv
// flash array behind the access block, byte programmable
`timescale 1ns/100ps
module flash_array_model (
  // clock
  input wire logic        clock,
  // read side
  input wire logic [15:0] code_addr,
  input wire logic [15:0] x_addr,
  output logic [7:0]      code_data,
  output logic [7:0]      x_data,
  // programming side
  input wire logic        flash_prog,
  input wire logic [13:0] flash_wr_addr,
  input wire logic [7:0]  flash_wr_data
);
  logic [7:0] mem [16384];  // one byte per flash address
  logic       prog_q = 1'b0; // stall seen last cycle
  // preset mixes both address bytes so a misdecode shows
  initial for (int i = 0; i < 16384; i++) mem[i] = i[7:0] ^ i[13:6] ^ 8'hA5;
  assign code_data = mem[code_addr[13:0]];
  assign x_data    = mem[x_addr[13:0]];
  // the byte lands only when the stall ends, never earlier
  // plain always here: the array is also preset by the initial block above
  always @(posedge clock) begin
    prog_q <= flash_prog;
    if (!flash_prog && prog_q) mem[flash_wr_addr] <= flash_wr_data;
  end
endmodule

// file: dv/flash_iap_monitor.sv
// checker: timing relations on the flash access block ports
`timescale 1ns/100ps
module flash_iap_monitor
  import flash_iap_pkg::*;
#(
  parameter int unsigned PROG_COUNT = 10
) (
  // clock and reset
  input wire logic                    clock,
  input wire logic                    rst,
  // inputs
  input wire logic                    por_load,
  input wire logic [7:0]              cfg_high_in,
  input wire logic [7:0]              cfg_low_in,
  input wire flash_iap_pkg::sfr_req_t sfr_req,
  input wire logic [15:0]             code_addr,
  input wire logic                    code_rd,
  input wire flash_iap_pkg::xdata_req_t x_req,
  // outputs
  input wire logic                    code_ok,
  input wire logic                    flash_prog,
  input wire logic                    cpu_wait,
  input wire logic                    irq_hold,
  input wire logic                    code_read_lock,
  input wire logic                    wide_write_flag,
  input wire logic [7:0]              config_word_low
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [15:0] hi_cnt; // cycles of the running stall
  logic        x_st;   // store taken while idle
  assign x_st = x_req.wr && !flash_prog;
  // a counter, since the stall is too long for a repetition
  always_ff @(posedge clock or posedge rst) begin
    if (rst) hi_cnt <= 16'h0000;
    else hi_cnt <= flash_prog ? hi_cnt + 16'h0001 : 16'h0000;
  end
  chk_stall_tied: assert property (cpu_wait == flash_prog && irq_hold == flash_prog)
    else $error("stall outputs disagree");
  chk_prog_end: assert property ($fell(flash_prog) |-> hi_cnt == PROG_COUNT)
    else $error("programming length wrong");
  chk_free_write: assert property (x_st && x_req.addr >= 16'h3F00 && x_req.addr <= FREE_END
    |=> flash_prog) else $error("free sector store refused");
  chk_main_gate: assert property (x_st && x_req.addr > LOCK_END && x_req.addr <= MAIN_END
    |=> flash_prog == $past(wide_write_flag)) else $error("main sector gate wrong");
  chk_lock_gate: assert property (x_st && x_req.addr <= LOCK_END
    |=> flash_prog == (!$past(code_read_lock) && $past(wide_write_flag)))
    else $error("lowest sector gate wrong");
  chk_wide_cmd: assert property (sfr_req.wr && sfr_req.addr == CMD_PORT_ADDR
    |=> wide_write_flag == ($past(sfr_req.wdata) == WIDE_KEY)) else $error("flag command");
  chk_code_gate: assert property (code_rd && code_addr <= 16'h3FFF
    |=> code_ok == !($past(code_read_lock) && $past(code_addr) <= LOCK_END))
    else $error("code read answer wrong");
  chk_cfg_load: assert property (por_load |=> config_word_low == $past(cfg_low_in)
    && code_read_lock == $past(cfg_high_in[LOCK_BIT_POS])) else $error("config load");
endmodule
bind flash_iap_access flash_iap_monitor #(.PROG_COUNT(PROG_COUNT)) u_flash_iap_monitor (
  .clock, .rst, .por_load, .cfg_high_in, .cfg_low_in, .sfr_req, .code_addr, .code_rd,
  .x_req, .code_ok, .flash_prog, .cpu_wait, .irq_hold, .code_read_lock,
  .wide_write_flag, .config_word_low);

// file: dv/tb.sv
// testbench: register, code and data accesses on the flash access block
`timescale 1ns/100ps
module tb;
  import flash_iap_pkg::*;
  localparam int unsigned PC = 10; // shortened programming length
  logic clock = 1'b0, rst = 1'b1, por_load = 1'b0, code_rd = 1'b0;
  logic [7:0] cfg_high_in = 8'h00, cfg_low_in = 8'h00, sfr_rdata, code_rdata, x_rdata;
  logic [7:0] fc, fx, flash_wr_data, config_word_low;
  logic [15:0] code_addr = 16'h0000;
  logic [13:0] flash_wr_addr;
  logic code_ok, x_ok, flash_prog, cpu_wait, irq_hold, soft_reset_trigger;
  logic code_read_lock, wide_write_flag;
  sfr_req_t sfr_req = '0;
  xdata_req_t x_req = '0;
  dspace_req_t d_req = '0;
  dspace_ans_t d_ans;
  int n_errors = 0, samples_checked = 0;
  flash_iap_access #(.PROG_COUNT(PC)) u_flash_iap_access (
    .clock, .rst, .por_load, .cfg_high_in, .cfg_low_in, .sfr_req, .sfr_rdata,
    .code_addr, .code_rd, .flash_code_in(fc), .code_rdata, .code_ok, .x_req,
    .flash_x_in(fx), .x_rdata, .x_ok, .flash_wr_addr, .flash_wr_data, .flash_prog,
    .cpu_wait, .irq_hold, .soft_reset_trigger, .code_read_lock, .wide_write_flag,
    .config_word_low, .d_req, .d_ans);
  flash_array_model u_flash_array_model (.clock, .code_addr, .x_addr(x_req.addr),
    .code_data(fc), .x_data(fx), .flash_prog, .flash_wr_addr, .flash_wr_data);
  initial forever #10 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  // preset flash contents, kept apart from the model's own code
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[13:6] ^ 8'hA5;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) sfr_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock) sfr_req <= '0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock) sfr_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock) sfr_req <= '0;
    #1 chk(sfr_rdata, e);
  endtask
  task automatic cd_rd(input logic [15:0] a, input logic ok, input logic [7:0] e);
    @(posedge clock) begin code_addr <= a; code_rd <= 1'b1; end
    @(posedge clock) code_rd <= 1'b0;
    #1 chk(code_ok, ok);
    chk(code_rdata, e);
  endtask
  task automatic x_rd(input logic [15:0] a, input logic ok, input logic [7:0] e);
    @(posedge clock) x_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock) x_req <= '0;
    #1 chk(x_ok, ok);
    chk(x_rdata, e);
  endtask
  // store, then measure how long the cpu is held
  task automatic x_wr(input logic [15:0] a, input logic [7:0] d, input logic p);
    int n;
    @(posedge clock) x_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock) x_req <= '0;
    #1 chk(flash_prog, p);
    n = 0;
    while (flash_prog === 1'b1 && n < 99) begin
      @(posedge clock) #1 n++;
    end
    chk(n, p ? PC : 0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the hundred-odd cycles the tests need
  initial begin
    #100000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock) begin por_load <= 1'b1; cfg_high_in <= 8'h20; cfg_low_in <= 8'h3C; end
    @(posedge clock) por_load <= 1'b0;
    #1 chk(code_read_lock, 1'b1);
    sfr_rd(CFG_SFR_ADDR, 8'h3C);
    sfr_rd(CMD_PORT_ADDR, 8'h00);
    cd_rd(16'h0100, 1'b0, 8'h00);
    cd_rd(16'h3FFF, 1'b1, pat(16'h3FFF));
    cd_rd(16'h0200, 1'b1, pat(16'h0200));
    cd_rd(16'h4000, 1'b0, 8'h00);
    x_wr(16'h0100, 8'h11, 1'b0);
    x_wr(16'h0300, 8'h22, 1'b0);
    x_wr(CFG_LOW_ADDR, 8'h33, 1'b0);
    // software is taken to have slowed the clock and raised the supply here
    // stimulus keeps clear of the emulation range 1d00h to 1fffh
    x_wr(16'h3F00, 8'h5A, 1'b1);
    x_rd(16'h3F00, 1'b1, 8'h5A);
    cd_rd(16'h3F00, 1'b1, 8'h5A);
    sfr_wr(CMD_PORT_ADDR, WIDE_KEY);
    sfr_rd(CMD_PORT_ADDR, 8'h01);
    x_wr(16'h0300, 8'h22, 1'b1);
    x_rd(16'h0300, 1'b1, 8'h22);
    x_wr(16'h0100, 8'h44, 1'b0);
    x_wr(CFG_HIGH_ADDR, 8'h55, 1'b0);
    x_wr(CFG_LOW_ADDR, 8'h66, 1'b1);
    sfr_wr(CMD_PORT_ADDR, 8'h64);
    sfr_rd(CMD_PORT_ADDR, 8'h00);
    x_wr(16'h3EFF, 8'h77, 1'b0);
    x_wr(16'hFE00, 8'h77, 1'b0);
    x_rd(16'hFE00, 1'b1, 8'h77);
    x_rd(16'h5000, 1'b0, 8'h00);
    sfr_wr(CFG_SFR_ADDR, 8'h9C);
    sfr_rd(CFG_SFR_ADDR, 8'h9C);
    // second power-on load, lock clear, other bits set
    @(posedge clock) begin por_load <= 1'b1; cfg_high_in <= 8'hDF; end
    @(posedge clock) por_load <= 1'b0;
    x_wr(16'h0100, 8'h88, 1'b0);
    sfr_wr(CMD_PORT_ADDR, WIDE_KEY);
    x_wr(16'h0100, 8'h88, 1'b1);
    cd_rd(16'h0100, 1'b1, 8'h88);
    // soft reset key gives a one-cycle trigger and clears the flag
    sfr_wr(CMD_PORT_ADDR, SOFT_RST_KEY);
    #1 chk(soft_reset_trigger, 1'b1);
    chk(wide_write_flag, 1'b0);
    @(posedge clock) #1 chk(soft_reset_trigger, 1'b0);
    // data space decode: bank register, then sfr versus upper ram
    @(posedge clock) d_req <= '{8'h90, 1'b0, 2'h2, 3'h5, 8'h00};
    @(posedge clock) d_req <= '{8'h90, 1'b1, 2'h2, 3'h5, 8'h00};
    #1 chk(d_ans.sfr_sel, 1'b1);
    chk(d_ans.reg_addr, 8'h15);
    chk(d_ans.bit_byte, 8'h20);
    chk(d_ans.bit_ok, 1'b1);
    @(posedge clock) #1 chk(d_ans.iram_sel, 1'b1);
    tally_and_finish;
  end
endmodule
